/* File: hw/xsbr_seq.sv */
// Sequencer for the repeating backward byte scan-and-translate.
// Assumes a same-clock memory port that answers with mem_ack and
// a register file that supplies operands at issue and takes write-back.
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "xsbr_consts.svh"
module xsbr_seq (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word0,
    input wire logic [15:0] instr_word1,
    input wire logic [31:0] ptr_in,
    input wire logic [31:0] base_in,
    input wire logic [15:0] cnt_in,
    input wire logic int_pending,
    output logic mem_req,
    output logic [31:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdata,
    output logic busy,
    output logic done,
    output logic suspended,
    output logic illegal,
    output logic [3:0] ptr_sel,
    output logic [3:0] cnt_sel,
    output logic [31:0] wb_ptr,
    output logic [15:0] wb_cnt,
    output logic [7:0] table_result_byte_reg,
    output logic flag_zero,
    output logic flag_count_zero
);
    import xsbr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    xsbr_state_t state_ff, nxt_state;
    xsbr_mode_t mode_ff;
    logic [31:0] ptr_ff, base_ff, mem_addr_ff, rdata_ff;
    logic [15:0] cnt_ff;
    logic [7:0] xlat_ff;
    logic [3:0] psel_ff, csel_ff;
    logic z_ff, v_ff, busy_ff, req_ff, done_ff, susp_ff, ill_ff;

    wire logic dec_ok;
    wire logic [3:0] dec_psel, dec_csel;
    wire logic [31:0] tbl_addr, dec_ptr;
    wire logic [15:0] cnt_dec;
    wire logic start, tgt_ack, tbl_ack, in_step, term, pause;
    wire logic ctrl_wr;

    xsbr_decode u_dec (
        .word0(instr_word0),
        .word1(instr_word1),
        .match(dec_ok),
        .ptr_sel(dec_psel),
        .cnt_sel(dec_csel),
        .base_sel()
    );

    // Live mode, so a mode change mid-string applies to the next lookup
    xsbr_addr u_tbl (
        .mode(mode_ff),
        .base(base_ff),
        .delta({24'h0, mem_rdata}),
        .sum(tbl_addr)
    );

    xsbr_addr u_step (
        .mode(mode_ff),
        .base(ptr_ff),
        .delta(32'hffffffff),
        .sum(dec_ptr)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencing
    assign start = (state_ff == XSBR_IDLE) && instr_valid && dec_ok;
    assign tgt_ack = (state_ff == XSBR_RD_TGT) && mem_ack;
    assign tbl_ack = (state_ff == XSBR_RD_TBL) && mem_ack;
    assign in_step = (state_ff == XSBR_STEP);
    assign cnt_dec = cnt_ff - 16'h1;
    assign term = (xlat_ff != 8'h0) || (cnt_dec == 16'h0);
    assign pause = !term && int_pending;

    always_comb begin
        case (state_ff)
            XSBR_IDLE: nxt_state = start ? XSBR_RD_TGT : XSBR_IDLE;
            XSBR_RD_TGT: nxt_state = mem_ack ? XSBR_RD_TBL : XSBR_RD_TGT;
            XSBR_RD_TBL: nxt_state = mem_ack ? XSBR_STEP : XSBR_RD_TBL;
            XSBR_STEP: nxt_state = (term || pause) ? XSBR_IDLE : XSBR_RD_TGT;
            default: nxt_state = XSBR_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_ff <= XSBR_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Operands; base only loads at issue and is never written back
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ptr_ff <= `XSBR_WORD_RST;
            base_ff <= `XSBR_WORD_RST;
            cnt_ff <= `XSBR_CNT_RST;
            psel_ff <= 4'h0;
            csel_ff <= 4'h0;
        end else if (start) begin
            ptr_ff <= xsbr_fit(mode_ff, ptr_in);
            base_ff <= xsbr_fit(mode_ff, base_in);
            cnt_ff <= cnt_in;
            psel_ff <= dec_psel;
            csel_ff <= dec_csel;
        end else if (in_step) begin
            ptr_ff <= dec_ptr;
            cnt_ff <= cnt_dec;
        end
    end

    // Flags: only zero and count-exhausted exist here; the rest are never touched
    always_ff @(posedge core_clk) begin
        if (reset) begin
            xlat_ff <= `XSBR_BYTE_RST;
            z_ff <= 1'b0;
            v_ff <= 1'b0;
        end else if (tbl_ack) begin
            xlat_ff <= mem_rdata;
            z_ff <= (mem_rdata == 8'h0);
        end else if (in_step) begin
            v_ff <= (cnt_dec == 16'h0);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory port: request held until acknowledged
    always_ff @(posedge core_clk) begin
        if (reset) begin
            req_ff <= 1'b0;
            mem_addr_ff <= `XSBR_WORD_RST;
        end else if (start) begin
            req_ff <= 1'b1;
            mem_addr_ff <= xsbr_fit(mode_ff, ptr_in);
        end else if (tgt_ack) begin
            mem_addr_ff <= tbl_addr;
        end else if (tbl_ack) begin
            req_ff <= 1'b0;
        end else if (in_step && !term && !pause) begin
            req_ff <= 1'b1;
            mem_addr_ff <= dec_ptr;
        end
    end

    // Busy level and completion pulses; a pause leaves pointer and counter ready for re-issue
    always_ff @(posedge core_clk) begin
        if (reset) begin
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            susp_ff <= 1'b0;
            ill_ff <= 1'b0;
        end else begin
            busy_ff <= (nxt_state != XSBR_IDLE);
            done_ff <= in_step && term;
            susp_ff <= in_step && pause;
            ill_ff <= (state_ff == XSBR_IDLE) && instr_valid && !dec_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register port; unmapped reads return zero
    assign ctrl_wr = reg_wr && (reg_addr == `XSBR_OFS_CTRL);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            mode_ff <= xsbr_mode_t'(`XSBR_MODE_RST);
        end else if (ctrl_wr && (reg_wdata[`XSBR_CTRL_MODE_LSB +: 2] != 2'h3)) begin
            mode_ff <= xsbr_mode_t'(reg_wdata[`XSBR_CTRL_MODE_LSB +: 2]);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdata_ff <= `XSBR_WORD_RST;
        end else if (reg_rd) begin
            case (reg_addr)
                `XSBR_OFS_CTRL: rdata_ff <= {30'h0, mode_ff};
                `XSBR_OFS_STATUS: rdata_ff <= {26'h0, state_ff, 1'b0, busy_ff, v_ff, z_ff};
                `XSBR_OFS_RESULT: rdata_ff <= {24'h0, xlat_ff};
                `XSBR_OFS_COUNT: rdata_ff <= {16'h0, cnt_ff};
                `XSBR_OFS_PTR: rdata_ff <= ptr_ff;
                default: rdata_ff <= `XSBR_WORD_RST;
            endcase
        end else begin
            rdata_ff <= `XSBR_WORD_RST;
        end
    end

    assign reg_rdata = rdata_ff;
    assign mem_req = req_ff;
    assign mem_addr = mem_addr_ff;
    assign busy = busy_ff;
    assign done = done_ff;
    assign suspended = susp_ff;
    assign illegal = ill_ff;
    assign ptr_sel = psel_ff;
    assign cnt_sel = csel_ff;
    assign wb_ptr = ptr_ff;
    assign wb_cnt = cnt_ff;
    assign table_result_byte_reg = xlat_ff;
    assign flag_zero = z_ff;
    assign flag_count_zero = v_ff;

    ////////////////////////////////////////////////////////////////////////
    a_tgt_addr:
    assert property (@(posedge core_clk) disable iff (reset)
        in_step && !term && !pause |=> mem_req && mem_addr == ptr_ff)
        else $error("target read not at string pointer");

    a_tbl_addr:
    assert property (@(posedge core_clk) disable iff (reset)
        tgt_ack && mode_ff == XSBR_LINEAR |=> mem_addr == base_ff + {24'h0, $past(mem_rdata)})
        else $error("table address is not base plus index");

    a_tbl_compact:
    assert property (@(posedge core_clk) disable iff (reset)
        tgt_ack && mode_ff == XSBR_COMPACT |=> mem_addr[31:16] == 16'h0)
        else $error("compact table address leaves 16 bits");

    a_result_load:
    assert property (@(posedge core_clk) disable iff (reset)
        tbl_ack |=> table_result_byte_reg == $past(mem_rdata) ##1 (done || busy || suspended))
        else $error("translated byte not loaded");

    a_ptr_step:
    assert property (@(posedge core_clk) disable iff (reset)
        in_step |=> wb_ptr[15:0] == $past(ptr_ff[15:0]) - 16'h1)
        else $error("string pointer did not step back");

    a_cnt_step:
    assert property (@(posedge core_clk) disable iff (reset)
        in_step |=> wb_cnt == $past(cnt_ff) - 16'h1)
        else $error("counter did not decrement");

    a_loop_stop:
    assert property (@(posedge core_clk) disable iff (reset)
        in_step && (xlat_ff != 8'h0 || cnt_ff == 16'h1) |=> done && !busy)
        else $error("loop did not stop");

    a_loop_more:
    assert property (@(posedge core_clk) disable iff (reset)
        in_step && xlat_ff == 8'h0 && cnt_ff != 16'h1 && !int_pending |=> !done && mem_req)
        else $error("loop stopped early");

    a_base_kept:
    assert property (@(posedge core_clk) disable iff (reset)
        busy && !start |=> $stable(base_ff))
        else $error("table base changed");

    a_flag_zero:
    assert property (@(posedge core_clk) disable iff (reset)
        done |-> flag_zero == (table_result_byte_reg == 8'h0))
        else $error("zero flag wrong");

    a_flag_count:
    assert property (@(posedge core_clk) disable iff (reset)
        done || suspended |-> flag_count_zero == (wb_cnt == 16'h0))
        else $error("count flag wrong");

    a_bad_code:
    assert property (@(posedge core_clk) disable iff (reset)
        !busy && instr_valid && !dec_ok |=> illegal && !busy)
        else $error("bad encoding not refused");

    a_pause:
    assert property (@(posedge core_clk) disable iff (reset)
        in_step && !term && int_pending |=> suspended && !busy && !mem_req)
        else $error("interrupt not taken between passes");

endmodule
`default_nettype wire

/* File: hw/xsbr_consts.svh */
// Constants of the backward scan-and-translate sequencer.
// Assumes inclusion by bare name from files under hw/.
`ifndef XSBR_CONSTS_SVH
`define XSBR_CONSTS_SVH

// Fixed bits of the two instruction words
`define XSBR_W0_TOP 8'hb8
`define XSBR_W0_LOW 4'he
`define XSBR_W1_TOP 4'h0
`define XSBR_W1_LOW 4'he

// Register port offsets
`define XSBR_OFS_CTRL 8'h00
`define XSBR_OFS_STATUS 8'h04
`define XSBR_OFS_RESULT 8'h08
`define XSBR_OFS_COUNT 8'h0c
`define XSBR_OFS_PTR 8'h10

// Field positions
`define XSBR_CTRL_MODE_LSB 0
`define XSBR_STAT_Z_BIT 0
`define XSBR_STAT_V_BIT 1
`define XSBR_STAT_BUSY_BIT 2
`define XSBR_STAT_STATE_LSB 4

// Reset values
`define XSBR_MODE_RST 2'h0
`define XSBR_WORD_RST 32'h0
`define XSBR_CNT_RST 16'h0
`define XSBR_BYTE_RST 8'h0

`endif

/* File: hw/xsbr_pkg.sv */
// Types of the backward scan-and-translate sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package xsbr_pkg;

    typedef enum logic [1:0] {
        XSBR_COMPACT = 2'h0,
        XSBR_SEGMENTED = 2'h1,
        XSBR_LINEAR = 2'h2
    } xsbr_mode_t;

    // Gray order from XSBR_IDLE to XSBR_STEP; the loop back to XSBR_RD_TGT flips both bits
    typedef enum logic [1:0] {
        XSBR_IDLE = 2'h0,
        XSBR_RD_TGT = 2'h1,
        XSBR_RD_TBL = 2'h3,
        XSBR_STEP = 2'h2
    } xsbr_state_t;

    // Compact mode sees only a 16-bit word register
    function automatic logic [31:0] xsbr_fit(input xsbr_mode_t m, input logic [31:0] v);
        xsbr_fit = (m == XSBR_COMPACT) ? {16'h0, v[15:0]} : v;
    endfunction

endpackage

/* File: hw/xsbr_decode.sv */
// Decoder of the two-word backward scan-and-translate encoding.
// Assumes both words are presented together and held stable.
`timescale 1ns/100ps
`default_nettype none
`include "xsbr_consts.svh"
module xsbr_decode (
    input wire logic [15:0] word0,
    input wire logic [15:0] word1,
    output logic match,
    output logic [3:0] ptr_sel,
    output logic [3:0] cnt_sel,
    output logic [3:0] base_sel
);
    wire logic w0_ok;
    wire logic w1_ok;

    assign ptr_sel = word0[7:4];
    assign cnt_sel = word1[11:8];
    assign base_sel = word1[7:4];
    assign w0_ok = (word0[15:8] == `XSBR_W0_TOP) && (word0[3:0] == `XSBR_W0_LOW);
    assign w1_ok = (word1[15:12] == `XSBR_W1_TOP) && (word1[3:0] == `XSBR_W1_LOW);
    // Register 0 cannot be an indirect pointer
    assign match = w0_ok && w1_ok && (ptr_sel != 4'h0) && (base_sel != 4'h0);
endmodule
`default_nettype wire

/* File: hw/xsbr_addr.sv */
// Mode-aware address adder, used for table lookup and pointer step.
// Assumes the base is already fitted to the active mode.
`timescale 1ns/100ps
`default_nettype none
module xsbr_addr (
    input wire xsbr_pkg::xsbr_mode_t mode,
    input wire logic [31:0] base,
    input wire logic [31:0] delta,
    output logic [31:0] sum
);
    import xsbr_pkg::*;
    wire logic [15:0] ofs_sum;

    assign ofs_sum = base[15:0] + delta[15:0];
    // Segmented sums never carry into the segment number
    assign sum = (mode == XSBR_LINEAR) ? base + delta :
                 (mode == XSBR_SEGMENTED) ? {base[31:16], ofs_sum} : {16'h0, ofs_sum};
endmodule
`default_nettype wire

/* File: dv/xsbr_mem_model.sv */
// Memory model: a byte store that answers the sequencer's read requests.
// Assumes the bench fills mem and drives the wait count of each reply.
`timescale 1ns/100ps
`default_nettype none
module xsbr_mem_model (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic [1:0] wait_in,
    output logic mem_ack,
    output logic [7:0] mem_rdata
);
    // String and table share one store of up to 256 table entries per base
    logic [7:0] mem [logic [31:0]];
    logic [1:0] wait_ff;
    logic [7:0] last_ff;

    ////////////////////////////////////////////////////////////////////////
    // Reply in the cycle the request is seen once the wait has run out
    assign mem_ack = mem_req && wait_ff == 2'h0;

    // Off-reply the data lines show the inverse, so stale bytes never pass
    always_comb begin
        if (mem_ack) begin
            mem_rdata = mem.exists(mem_addr) ? mem[mem_addr] : 8'h00;
        end else begin
            mem_rdata = ~last_ff;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            wait_ff <= 2'h0;
            last_ff <= 8'h00;
        end else if (mem_ack) begin
            wait_ff <= wait_in;
            last_ff <= mem_rdata;
        end else if (mem_req && wait_ff != 2'h0) begin
            wait_ff <= wait_ff - 2'h1;
        end
    end
endmodule
`default_nettype wire

/* File: dv/xsbr_seq_tb.sv */
// Self-checking bench of the backward scan-and-translate sequencer.
// Assumes xsbr_pkg, the design files and the memory model compile first.
`timescale 1ns/100ps
`default_nettype none
`include "xsbr_consts.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module xsbr_seq_tb;
    import xsbr_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, ptr_in = 32'h0, base_in = 32'h0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, instr_valid = 1'b0, int_pending = 1'b0;
    logic [15:0] instr_word0 = 16'h0, instr_word1 = 16'h0, cnt_in = 16'h0;
    logic [1:0] wait_in = 2'h0;
    logic [31:0] reg_rdata, mem_addr, wb_ptr, er, seed = 32'hb664;
    logic mem_req, mem_ack, busy, done, suspended, illegal, flag_zero, flag_count_zero;
    logic rd_seen = 1'b0;
    logic [7:0] mem_rdata, table_result_byte_reg;
    logic [3:0] ptr_sel, cnt_sel;
    logic [15:0] wb_cnt;
    logic [67:0] ex;
    logic [31:0] rq [$];
    logic [67:0] xq [$];
    int errors = 0, n_checks = 0;
    xsbr_mode_t mode = XSBR_COMPACT;
    wire logic [67:0] got = {done ? 2'h0 : (suspended ? 2'h1 : 2'h2), illegal ? 66'h0 :
        {wb_ptr, wb_cnt, table_result_byte_reg, flag_zero, flag_count_zero, ptr_sel, cnt_sel}};

    always #4 core_clk = ~core_clk;

    xsbr_seq i_dut (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .instr_valid, .instr_word0, .instr_word1, .ptr_in, .base_in, .cnt_in, .int_pending,
        .mem_req, .mem_addr, .mem_ack, .mem_rdata, .busy, .done, .suspended, .illegal,
        .ptr_sel, .cnt_sel, .wb_ptr, .wb_cnt, .table_result_byte_reg, .flag_zero,
        .flag_count_zero);
    xsbr_mem_model i_mem (.core_clk, .reset, .mem_req, .mem_addr, .wait_in, .mem_ack,
        .mem_rdata);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Segmented keeps the segment half, compact has no upper half at all
    function automatic logic [31:0] adr(xsbr_mode_t m, logic [31:0] a, logic [31:0] d);
        logic [15:0] lo;
        lo = a[15:0] + d[15:0];
        return m == XSBR_LINEAR ? a + d : {m == XSBR_SEGMENTED ? a[31:16] : 16'h0, lo};
    endfunction

    // Bytes never set up are made on first touch, mostly zero, so loops run on
    function automatic logic [7:0] mb(logic [31:0] a);
        logic [31:0] x;
        x = rnd();
        if (!i_mem.mem.exists(a)) i_mem.mem[a] = x[1:0] == 2'h0 ? x[15:8] : 8'h00;
        return i_mem.mem[a];
    endfunction

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(logic [7:0] a, logic [31:0] e);
        rq.push_back(e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask

    task automatic set_mode(xsbr_mode_t m);
        wr(`XSBR_OFS_CTRL, {30'h0, m});
        mode = m;
        wr(`XSBR_OFS_CTRL, 32'h3);
        rd(`XSBR_OFS_CTRL, {30'h0, m});
    endtask

    task automatic run(logic [15:0] w0, logic [15:0] w1, logic [31:0] p0, logic [31:0] b0,
            logic [15:0] c0, logic intr);
        logic [31:0] p, b;
        logic [15:0] c;
        logic [7:0] rh;
        logic ok;
        ok = w0[15:8] == `XSBR_W0_TOP && w0[3:0] == `XSBR_W0_LOW && w0[7:4] != 4'h0 &&
            w1[15:12] == `XSBR_W1_TOP && w1[3:0] == `XSBR_W1_LOW && w1[7:4] != 4'h0;
        p = mode == XSBR_COMPACT ? {16'h0, p0[15:0]} : p0;
        b = mode == XSBR_COMPACT ? {16'h0, b0[15:0]} : b0;
        c = c0;
        if (ok) begin
            do begin
                rh = mb(adr(mode, b, {24'h0, mb(p)}));
                p = adr(mode, p, 32'hffffffff);
                c = c - 16'h1;
            end while (rh == 8'h00 && c != 16'h0 && !intr);
        end
        xq.push_back(!ok ? {2'h2, 66'h0} : {rh == 8'h00 && c != 16'h0 ? 2'h1 : 2'h0,
            p, c, rh, rh == 8'h00, c == 16'h0, w0[7:4], w1[11:8]});
        @(posedge core_clk);
        instr_word0 <= w0;
        instr_word1 <= w1;
        ptr_in <= p0;
        base_in <= b0;
        cnt_in <= c0;
        int_pending <= intr;
        instr_valid <= 1'b1;
        @(posedge core_clk);
        instr_valid <= 1'b0;
        repeat (3000) if (!(done || suspended || illegal)) @(posedge core_clk);
        int_pending <= 1'b0;
    endtask

    task automatic report_and_stop();
        if (errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk) begin
        wait_in <= seed[1:0];
        if (rd_seen) begin
            er = rq.pop_front();
            `CHK("reg_rdata", er, reg_rdata)
        end
        rd_seen = reg_rd;
        if (done || suspended || illegal) begin
            ex = xq.pop_front();
            `CHK("outcome", ex, got)
            `CHK("busy_at_end", 1'b0, busy)
        end
        // A pending memory request means a string is still being worked on
        if (mem_req) begin
            `CHK("busy_in_loop", 1'b1, busy)
        end
    end

    initial begin
        repeat (60000) @(posedge core_clk);
        errors++;
        report_and_stop();
    end

    initial begin
        logic [31:0] bad [4];
        logic [31:0] x;
        bad = '{32'hb80e0c9e, 32'hb86e0c0e, 32'hb86a0c9e, 32'hb86e1c9e};
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        i_mem.mem[32'h4000] = 8'h00;
        i_mem.mem[32'h4001] = 8'h40;
        i_mem.mem[32'h4002] = 8'h80;
        for (int i = 0; i < 256; i++) i_mem.mem[32'h1000 + i] = i[7:0] & 8'h7f;
        // Distinct pointer, counter and base fields throughout
        run(16'hb86e, 16'h0c9e, 32'h4002, 32'h1000, 16'h3, 1'b0);
        rd(`XSBR_OFS_STATUS, 32'h0);
        rd(`XSBR_OFS_RESULT, 32'h40);
        rd(`XSBR_OFS_COUNT, 32'h1);
        rd(`XSBR_OFS_PTR, 32'h4000);
        rd(8'h20, 32'h0);
        run(16'hb86e, 16'h0c9e, 32'h4000, 32'h1000, 16'h1, 1'b0);
        rd(`XSBR_OFS_STATUS, 32'h3);
        run(16'hb86e, 16'h0c9e, 32'habcd4002, 32'h77771000, 16'h0, 1'b0);
        run(16'hb86e, 16'h0c9e, 32'h4002, 32'h1000, 16'h3, 1'b1);
        run(16'hb86e, 16'h0c9e, 32'h4001, 32'h1000, 16'h2, 1'b0);
        for (int i = 0; i < 4; i++) run(bad[i][31:16], bad[i][15:0], 32'h4002, 32'h1000,
            16'h3, 1'b0);
        for (int m = 2; m >= 0; m--) begin
            set_mode(xsbr_mode_t'(m));
            run(16'hb86e, 16'h0c9e, 32'h00120000, 32'h0034fff0, 16'h5, 1'b0);
        end
        for (int t = 0; t < 40; t++) begin
            x = rnd();
            set_mode(xsbr_mode_t'(x[9:8] % 2'h3));
            run(16'hb86e, 16'h0c9e, {x[31:16], 2'h1, x[13:0]}, {~x[31:16], 2'h2, x[29:16]},
                {12'h0, x[3:0]}, x[7:4] == 4'h0);
        end
        repeat (3) @(posedge core_clk);
        `CHK("pending", 0, xq.size() + rq.size())
        report_and_stop();
    end
endmodule
`default_nettype wire
